// [rtl/stvs_consts.vh]
`ifndef STVS_CONSTS_VH
`define STVS_CONSTS_VH

// register byte offsets
`define STVS_ADDR_CTRL 4'h0
`define STVS_ADDR_STATUS 4'h4
`define STVS_ADDR_W 4
// one-hot register selects from the address decoder
`define STVS_SEL_CTRL 3'b001
`define STVS_SEL_STATUS 3'b010
`define STVS_SEL_NONE 3'b100
`define STVS_SEL_CTRL_BIT 0
`define STVS_SEL_STAT_BIT 1
// control register fields
`define STVS_CTRL_MODE_BIT 0
`define STVS_CTRL_RST_BIT 1
`define STVS_CTRL_RESET 2'h0
// status register fields
`define STVS_STAT_DONE_BIT 0
`define STVS_STAT_ERR_BIT 1
// mode encoding
`define STVS_MODE_BIST 1'b0
`define STVS_MODE_PRBS 1'b1
// least error flag hold in prbs mode, in receive clock cycles
`define STVS_ERR_MIN_CYC 2'h3
`define STVS_ERR_CNT_W 2
`define STVS_ERR_CNT_CLR 2'h0
// axi responses
`define STVS_RESP_OKAY 2'h0
`define STVS_RESP_SLVERR 2'h2

`endif

// [rtl/stvs_status.v]
// Overview of operation
// [R1] bist mode: done goes high on full pattern or error, holds until reset
// [R2] prbs mode: done goes high on full pattern, holds until reset
// [R3] bist mode: error flag latches on mismatch, holds until reset
// [R4] prbs mode: error flag stays high at least three receive clock cycles
// [R5] prbs mode: error flag drops after minimum if next sequence is clean; a mismatch on the sequence end cycle holds it until a second clean end
// [R6] monitor picks mode and applies receive reset before reading results
`timescale 1ns/1ns
`include "stvs_consts.vh"

module stvs_status (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_pattern_done,
   input wire i_mismatch,
   input wire [3:0] i_awaddr,
   input wire i_awvalid,
   output reg o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [3:0] i_araddr,
   input wire i_arvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   output reg o_test_done,
   output reg o_test_err
);

   reg [1:0] ctrl;
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg w_lane0;
   reg [1:0] err_cnt;
   reg seq_open;
   reg drop_due;
   wire [2:0] wr_sel;
   wire [2:0] rd_sel;
   wire mode_prbs;
   wire rx_reset;
   wire wr_go;
   wire rd_go;

   // shared by the write and read paths, so both refuse the same holes
   function [2:0] stvs_dec;
      input [3:0] addr;
      begin
         if (addr == `STVS_ADDR_CTRL) begin
            stvs_dec = `STVS_SEL_CTRL;
         end else if (addr == `STVS_ADDR_STATUS) begin
            stvs_dec = `STVS_SEL_STATUS;
         end else begin
            stvs_dec = `STVS_SEL_NONE;
         end
      end
   endfunction

   assign wr_sel = stvs_dec(aw_addr);
   assign rd_sel = stvs_dec(i_araddr);
   assign mode_prbs = ctrl[`STVS_CTRL_MODE_BIT];
   // the receive digital reset is a software-held bit; while it is high
   // both flags stay cleared and no event is latched
   assign rx_reset = ctrl[`STVS_CTRL_RST_BIT];
   // the response waits for both halves; a second write stalls on the
   // readies, which stay low until the response has been taken
   assign wr_go = aw_held & w_held & ~o_bvalid;
   assign rd_go = i_arvalid & o_arready;

   // write address and data are taken in either order
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_lane0 <= 1'b0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `STVS_RESP_OKAY;
         ctrl <= `STVS_CTRL_RESET;
      end else begin
         if (i_awvalid & o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid & o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_lane0 <= i_wstrb[0];
            o_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_bvalid <= 1'b1;
            if (wr_sel[`STVS_SEL_CTRL_BIT]) begin
               o_bresp <= `STVS_RESP_OKAY;
               if (w_lane0) begin
                  ctrl <= w_data[1:0];
               end
            end else if (wr_sel[`STVS_SEL_STAT_BIT]) begin
               o_bresp <= `STVS_RESP_OKAY;
            end else begin
               o_bresp <= `STVS_RESP_SLVERR;
            end
         end
         if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // read data is captured at the take, so the status word shows the
   // flags as they stood one cycle before rvalid rises
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= `STVS_RESP_OKAY;
      end else begin
         if (rd_go) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= 32'h0;
            o_rresp <= `STVS_RESP_OKAY;
            if (rd_sel[`STVS_SEL_CTRL_BIT]) begin
               o_rdata[1:0] <= ctrl;
            end else if (rd_sel[`STVS_SEL_STAT_BIT]) begin
               o_rdata[`STVS_STAT_DONE_BIT] <= o_test_done;
               o_rdata[`STVS_STAT_ERR_BIT] <= o_test_err;
            end else begin
               o_rresp <= `STVS_RESP_SLVERR;
            end
         end
         if (o_rvalid & i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // verifier indications come from the same clock domain, so no
   // synchroniser; the clock is taken as the receive parallel clock

   // completion flag: sticky in both modes until the receive reset
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_test_done <= 1'b0;
      end else if (rx_reset) begin
         o_test_done <= 1'b0;
      end else if (mode_prbs == `STVS_MODE_BIST) begin
         if (i_pattern_done | i_mismatch) begin
            o_test_done <= 1'b1; // [R1]
         end
      end else begin
         if (i_pattern_done) begin
            o_test_done <= 1'b1; // [R2]
         end
      end
   end

   // error flag: sticky in bist mode, held and then released in prbs
   // mode; a mode change alone leaves it as it is
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_test_err <= 1'b0;
         err_cnt <= `STVS_ERR_CNT_CLR;
         seq_open <= 1'b0;
         drop_due <= 1'b0;
      end else if (rx_reset) begin
         o_test_err <= 1'b0;
         err_cnt <= `STVS_ERR_CNT_CLR;
         seq_open <= 1'b0;
         drop_due <= 1'b0;
      end else if (mode_prbs == `STVS_MODE_BIST) begin
         if (i_mismatch) begin
            o_test_err <= 1'b1; // [R3]
         end
      end else if (i_mismatch) begin
         // a new error restarts the hold and reopens the sequence
         o_test_err <= 1'b1; // [R4]
         err_cnt <= `STVS_ERR_MIN_CYC - 2'h1; // [R4]
         seq_open <= 1'b1;
         drop_due <= 1'b0;
      end else begin
         if (err_cnt != `STVS_ERR_CNT_CLR) begin
            err_cnt <= err_cnt - 2'h1; // [R4]
         end
         // the first sequence end after an error closes the erroring
         // sequence; the next end with no mismatch releases the flag
         if (i_pattern_done & seq_open) begin
            seq_open <= 1'b0;
         end else if ((i_pattern_done | drop_due) & o_test_err) begin
            // a clean end inside the minimum hold waits for the counter
            if (err_cnt == `STVS_ERR_CNT_CLR) begin
               o_test_err <= 1'b0; // [R5]
               drop_due <= 1'b0;
            end else begin
               drop_due <= 1'b1;
            end
         end
      end
   end

endmodule

// [tb/stvs_status_checker.sv]
`timescale 1ns/1ns
module stvs_status_checker (
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_pattern_done,
   input wire i_mismatch,
   input wire o_bvalid,
   input wire o_test_done,
   input wire o_test_err
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // done only falls via the rx reset write, seen through bvalid; err may also fall after i_pattern_done
   a_done_cause: assert property ($rose(o_test_done) |->
      $past(i_pattern_done | i_mismatch)) else $error("done without cause");
   a_done_hold: assert property ($fell(o_test_done) |->
      $past(o_bvalid) || $past(o_bvalid, 2)) else $error("done dropped");
   a_err_cause: assert property ($rose(o_test_err) |->
      $past(i_mismatch)) else $error("err without mismatch");
   a_err_min: assert property ($rose(o_test_err) |->
      o_test_err [*3]) else $error("err too short");
   a_err_drop: assert property ($fell(o_test_err) |->
      $past(i_pattern_done) || $past(o_bvalid) || $past(o_bvalid, 2))
      else $error("err dropped early");
endmodule
bind stvs_status stvs_status_checker chk (.*);

// [tb/stvs_src.sv]
`timescale 1ns/1ns
module stvs_src (
   input wire i_clk_sys,
   input wire i_go,
   input wire [3:0] i_len,
   input wire [3:0] i_bad,
   output reg o_pattern_done = 1'h0,
   output reg o_mismatch = 1'h0,
   output reg o_busy = 1'h0
);
   reg [3:0] cnt = 4'h0;
   // one sequence of i_len words; i_bad of 0 means clean
   always @(posedge i_clk_sys) begin
      o_mismatch <= o_busy && cnt == i_bad;
      o_pattern_done <= o_busy && cnt == i_len;
      cnt <= i_go ? 4'h1 : cnt + 4'h1;
      o_busy <= i_go || (o_busy && cnt != i_len);
   end
endmodule

// [tb/stvs_status_tb.sv]
`timescale 1ns/1ns
module stvs_status_tb;
   reg i_clk_sys = 1'h0, i_rst = 1'h1, i_awvalid = 1'h0, i_wvalid = 1'h0;
   reg i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0, go = 1'h0;
   reg [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
   reg [3:0] len = 4'h8, bad = 4'h0;
   reg [31:0] i_wdata = 32'h0, mismatches = 32'h0, n_compared = 32'h0;
   reg [33:0] v;
   wire i_pattern_done, i_mismatch, busy, o_awready, o_wready, o_bvalid;
   wire o_arready, o_rvalid, o_test_done, o_test_err;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   stvs_status uut (.*);
   stvs_src src (.i_clk_sys, .i_go(go), .i_len(len), .i_bad(bad),
      .o_pattern_done(i_pattern_done), .o_mismatch(i_mismatch), .o_busy(busy));
   always #2 i_clk_sys = ~i_clk_sys;
   task chk(input [33:0] s, input [33:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         i_awaddr <= a;
         i_wdata <= d;
         i_awvalid <= 1'h1;
         i_wvalid <= 1'h1;
         i_bready <= 1'h1;
         do begin
            @(posedge i_clk_sys);
            if (o_awready) i_awvalid <= 1'h0;
            if (o_wready) i_wvalid <= 1'h0;
         end while (!o_bvalid);
         v = {o_bresp, 32'h0};
         i_bready <= 1'h0;
         @(posedge i_clk_sys);
      end
   endtask
   task rd(input [3:0] a);
      begin
         i_araddr <= a;
         i_arvalid <= 1'h1;
         i_rready <= 1'h1;
         do begin
            @(posedge i_clk_sys);
            if (o_arready) i_arvalid <= 1'h0;
         end while (!o_rvalid);
         v = {o_rresp, o_rdata};
         i_rready <= 1'h0;
         @(posedge i_clk_sys);
      end
   endtask
   task st(input [1:0] e);
      begin
         rd(4'h4);
         chk(v, {32'h0, e});
      end
   endtask
   // random length kept above the read latency so mid-run reads are safe
   task seq(input [3:0] b);
      begin
         len <= 4'h8 + $urandom % 8;
         bad <= b;
         go <= 1'h1;
         @(posedge i_clk_sys);
         go <= 1'h0;
      end
   endtask
   task fin;
      begin
         do @(posedge i_clk_sys); while (busy);
         repeat (2) @(posedge i_clk_sys);
      end
   endtask
   task report_and_stop;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      void'($urandom(32'h56d3db64));
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      @(posedge i_clk_sys);
      rd(4'h0);
      chk(v, 34'h0);
      rd(4'h8);
      chk({32'h0, v[33:32]}, 34'h2);
      wr(4'h8, 32'h3);
      chk({32'h0, v[33:32]}, 34'h2);
      seq(4'h1);
      repeat (3) @(posedge i_clk_sys);
      st(2'h3);
      fin;
      seq(4'h0);
      fin;
      st(2'h3);
      wr(4'h0, 32'h2);
      chk(v, 34'h0);
      wr(4'h0, 32'h0);
      st(2'h0);
      seq(4'h0);
      fin;
      st(2'h1);
      wr(4'h0, 32'h3);
      wr(4'h0, 32'h1);
      seq(4'h1);
      repeat (3) @(posedge i_clk_sys);
      st(2'h2);
      fin;
      st(2'h3);
      seq(4'h0);
      fin;
      st(2'h1);
      report_and_stop;
   end
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      mismatches = mismatches + 1;
      report_and_stop;
   end
endmodule
